// ### rtl/guest_mailbox_pkg.sv
package guest_mailbox_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] MAILBOX_OFFSET = 12'h200;
    localparam logic [11:0] MAILBOX_SPAN_MASK = 12'hf00;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int PEND_BIT    = 25;
    localparam int TIMEOUT_BIT = 24;
    localparam int DIR_BIT     = 23;
    localparam int GUEST_LSB   = 20;
    localparam int REGSEL_LSB  = 16;
    localparam int BYTE_LSB    = 0;
    localparam logic       DIR_RESET    = 1'h1;
    localparam logic [2:0] GUEST_RESET  = 3'h0;
    localparam logic [2:0] REGSEL_RESET = 3'h0;
    localparam logic [7:0] BYTE_RESET   = 8'h00;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int TIMEOUT_CLOCKS = 64;
    localparam logic [6:0] TIMEOUT_LIMIT = 7'(TIMEOUT_CLOCKS);
    localparam logic [6:0] COUNT_ONE     = 7'h01;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_ACTIVE = 3'b010,
        ST_FINISH = 3'b100
    } cycle_state_t;

    typedef struct packed {
        logic [7:0] guestChipSelect;
        logic [2:0] guestAddress;
        logic       guestReadStrobe;
        logic       guestWriteStrobe;
    } guest_ctrl_t;

endpackage

// ### rtl/guest_bus_mailbox_port.sv
`timescale 1ns/1ns
// Function
// - writing the transfer byte field while the sequencer is idle sets the pending flag
// - pending clears when the guest cycle ends or times out
// - host access colliding with internal pending update leaves pending zero
// - timeout flag sets when a cycle lasts longer than 64 clocks
// - guest stretches a cycle with wait low; too long gives a timeout
// - timeout flag clears only on host write of one
// - new timeout beats a simultaneous host clear
// - direction bit: zero reads guest, one writes guest; resets to one
// - guest field decodes to exactly one of eight chip selects
// - register field drives the three guest address lines
// - eight-bit transfer byte, sent on writes, loaded on reads, resets zero
module guest_bus_mailbox_port (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // peripheral local bus
    output guest_mailbox_pkg::guest_ctrl_t guestCtrl,
    output logic      [7:0]  guestDataOut,
    output logic             guestDataOutEn,
    input  wire logic [7:0]  guestDataIn,
    input  wire logic        guestWaitStrobe_n
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    guest_mailbox_pkg::cycle_state_t state_reg, state_next;
    logic       pending_reg;
    logic       timeout_reg;
    logic       dir_reg;
    logic [2:0] guest_reg;
    logic [2:0] regSel_reg;
    logic [7:0] byte_reg;
    logic [6:0] count_reg, count_next;
    logic       ack_reg;
    logic [31:0] rdata_reg;
    guest_mailbox_pkg::guest_ctrl_t ctrl_reg, ctrl_next;
    logic       dataOutEn_reg;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire logic request   = wb_cyc_i & wb_stb_i & ~ack_reg;
    wire logic hitMbox   = (wb_adr_i & guest_mailbox_pkg::MAILBOX_SPAN_MASK) == guest_mailbox_pkg::MAILBOX_OFFSET;
    wire logic wrMbox    = request & wb_we_i & hitMbox;
    wire logic rdMbox    = request & ~wb_we_i & hitMbox;
    wire logic wrByte    = wrMbox & wb_sel_i[0];
    wire logic wrCtrl    = wrMbox & wb_sel_i[2];
    wire logic wrStatus  = wrMbox & wb_sel_i[3];
    wire logic clearTo   = wrStatus & wb_dat_i[guest_mailbox_pkg::TIMEOUT_BIT];
    wire logic idle      = state_reg == guest_mailbox_pkg::ST_IDLE;
    wire logic startCyc  = wrByte & idle;
    wire logic overTime  = (state_reg == guest_mailbox_pkg::ST_ACTIVE) &&
                           (count_reg == guest_mailbox_pkg::TIMEOUT_LIMIT) && ~guestWaitStrobe_n;
    wire logic doneCyc   = (state_reg == guest_mailbox_pkg::ST_ACTIVE) & guestWaitStrobe_n;
    wire logic endCyc    = doneCyc | overTime;
    wire logic hostTouch = rdMbox | wrMbox;

    logic [31:0] readWord;

    // ------------------------------------------------------------
    // read word assembly
    // ------------------------------------------------------------
    always_comb begin
        readWord                                     = '0;
        readWord[guest_mailbox_pkg::PEND_BIT]        = pending_reg;
        readWord[guest_mailbox_pkg::TIMEOUT_BIT]     = timeout_reg;
        readWord[guest_mailbox_pkg::DIR_BIT]         = dir_reg;
        readWord[guest_mailbox_pkg::GUEST_LSB +: 3]  = guest_reg;
        readWord[guest_mailbox_pkg::REGSEL_LSB +: 3] = regSel_reg;
        readWord[guest_mailbox_pkg::BYTE_LSB +: 8]   = byte_reg;
    end

    // ------------------------------------------------------------
    // guest cycle sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        ctrl_next  = ctrl_reg;
        case (state_reg)
            guest_mailbox_pkg::ST_IDLE: begin
                if (startCyc) begin
                    state_next                 = guest_mailbox_pkg::ST_ACTIVE;
                    count_next                 = guest_mailbox_pkg::COUNT_ONE;
                    ctrl_next.guestChipSelect  = 8'h01 << guest_reg;
                    ctrl_next.guestAddress     = regSel_reg;
                    ctrl_next.guestWriteStrobe = dir_reg;
                    ctrl_next.guestReadStrobe  = ~dir_reg;
                end
            end
            guest_mailbox_pkg::ST_ACTIVE: begin
                count_next = count_reg + guest_mailbox_pkg::COUNT_ONE;
                if (endCyc) begin
                    state_next = guest_mailbox_pkg::ST_FINISH;
                    ctrl_next  = '0;
                end
            end
            guest_mailbox_pkg::ST_FINISH: begin
                state_next = guest_mailbox_pkg::ST_IDLE;
            end
            default: begin
                state_next = guest_mailbox_pkg::ST_IDLE;
                ctrl_next  = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg     <= guest_mailbox_pkg::ST_IDLE;
            count_reg     <= '0;
            ctrl_reg      <= '0;
            dataOutEn_reg <= 1'h0;
        end else begin
            state_reg     <= state_next;
            count_reg     <= count_next;
            ctrl_reg      <= ctrl_next;
            dataOutEn_reg <= ctrl_next.guestWriteStrobe;
        end
    end

    // ------------------------------------------------------------
    // mailbox register fields
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dir_reg    <= guest_mailbox_pkg::DIR_RESET;
            guest_reg  <= guest_mailbox_pkg::GUEST_RESET;
            regSel_reg <= guest_mailbox_pkg::REGSEL_RESET;
            byte_reg   <= guest_mailbox_pkg::BYTE_RESET;
        end else begin
            if (wrCtrl && idle) begin
                dir_reg    <= wb_dat_i[guest_mailbox_pkg::DIR_BIT];
                guest_reg  <= wb_dat_i[guest_mailbox_pkg::GUEST_LSB +: 3];
                regSel_reg <= wb_dat_i[guest_mailbox_pkg::REGSEL_LSB +: 3];
            end
            if (startCyc) begin
                byte_reg <= wb_dat_i[guest_mailbox_pkg::BYTE_LSB +: 8];
            end else if (doneCyc && !ctrl_reg.guestWriteStrobe) begin
                byte_reg <= guestDataIn;
            end
        end
    end

    // ------------------------------------------------------------
    // pending and timeout flags
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pending_reg <= 1'h0;
            timeout_reg <= 1'h0;
        end else begin
            if (endCyc) begin
                pending_reg <= 1'h0;
            end else if (startCyc) begin
                pending_reg <= 1'h1;
            end
            if (overTime) begin
                timeout_reg <= 1'h1;
            end else if (clearTo) begin
                timeout_reg <= 1'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ack_reg   <= 1'h0;
            rdata_reg <= '0;
        end else begin
            ack_reg   <= request;
            rdata_reg <= (request && !wb_we_i && hitMbox) ? readWord : 32'h0000_0000;
        end
    end

    assign wb_ack_o       = ack_reg;
    assign wb_dat_o       = rdata_reg;
    assign guestCtrl      = ctrl_reg;
    assign guestDataOut   = byte_reg;
    assign guestDataOutEn = dataOutEn_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_pend_on_start: assert property (@(posedge clk) disable iff (!reset_n)
        startCyc |=> pending_reg)
        else $error("pending not set after byte write");
    a_pend_clear: assert property (@(posedge clk) disable iff (!reset_n)
        endCyc |=> !pending_reg)
        else $error("pending not cleared at cycle end");
    a_pend_collide: assert property (@(posedge clk) disable iff (!reset_n)
        (endCyc && hostTouch) |=> !pending_reg)
        else $error("pending not zero on collision");
    a_timeout_set: assert property (@(posedge clk) disable iff (!reset_n)
        (state_reg == guest_mailbox_pkg::ST_ACTIVE && !guestWaitStrobe_n)[*8] |-> ##[0:64] (timeout_reg || !pending_reg))
        else $error("stretched cycle never timed out");
    a_timeout_hold: assert property (@(posedge clk) disable iff (!reset_n)
        (timeout_reg && !clearTo) |=> timeout_reg)
        else $error("timeout cleared without write of one");
    a_timeout_wins: assert property (@(posedge clk) disable iff (!reset_n)
        (overTime && clearTo) |=> timeout_reg)
        else $error("clear beat new timeout");
    a_cs_onehot: assert property (@(posedge clk) disable iff (!reset_n)
        (state_reg == guest_mailbox_pkg::ST_ACTIVE) |-> $onehot(guestCtrl.guestChipSelect))
        else $error("chip select not one-hot");
    a_addr_match: assert property (@(posedge clk) disable iff (!reset_n)
        (state_reg == guest_mailbox_pkg::ST_ACTIVE) |-> guestCtrl.guestAddress == regSel_reg)
        else $error("address lines differ from field");
    a_dir_strobe: assert property (@(posedge clk) disable iff (!reset_n)
        (state_reg == guest_mailbox_pkg::ST_ACTIVE) |-> guestCtrl.guestWriteStrobe == dir_reg)
        else $error("strobe differs from direction");
    a_byte_drive: assert property (@(posedge clk) disable iff (!reset_n)
        (guestDataOutEn && $past(guestDataOutEn)) |-> $stable(guestDataOut))
        else $error("driven byte changed during write");
    a_timeout_idle: assert property (@(posedge clk) disable iff (!reset_n)
        overTime |=> guestCtrl.guestChipSelect == 8'h00 ##1 idle)
        else $error("bus not released after timeout");

    // ------------------------------------------------------------
    // reset and bus answer checks
    // ------------------------------------------------------------

    a_reset_fields: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(reset_n) |-> (dir_reg && guest_reg == 3'h0 && regSel_reg == 3'h0 && byte_reg == 8'h00 && !pending_reg))
        else $error("field not at reset value");

    a_ack_after_req: assert property (@(posedge clk) disable iff (!reset_n)
        request |=> wb_ack_o)
        else $error("request not acknowledged");

    a_ack_pulse: assert property (@(posedge clk) disable iff (!reset_n)
        wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");

    a_rdata_zero: assert property (@(posedge clk) disable iff (!reset_n)
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside answer");

    a_ack_read: assert property (@(posedge clk) disable iff (!reset_n)
        (wb_ack_o && $past(rdMbox)) |-> wb_dat_o == $past(readWord))
        else $error("read data differs from register");

    // ------------------------------------------------------------
    // sequencer checks
    // ------------------------------------------------------------

    a_fsm_onehot: assert property (@(posedge clk) disable iff (!reset_n)
        $onehot(state_reg))
        else $error("sequencer state not one-hot");

    a_finish_idle: assert property (@(posedge clk) disable iff (!reset_n)
        (state_reg == guest_mailbox_pkg::ST_FINISH) |=> idle)
        else $error("finish did not return to idle");

    a_count_start: assert property (@(posedge clk) disable iff (!reset_n)
        startCyc |=> count_reg == guest_mailbox_pkg::COUNT_ONE)
        else $error("cycle counter not restarted");

    a_count_bound: assert property (@(posedge clk) disable iff (!reset_n)
        (state_reg == guest_mailbox_pkg::ST_ACTIVE) |-> count_reg <= guest_mailbox_pkg::TIMEOUT_LIMIT)
        else $error("cycle ran past timeout limit");

    a_pend_busy: assert property (@(posedge clk) disable iff (!reset_n)
        pending_reg == (state_reg == guest_mailbox_pkg::ST_ACTIVE))
        else $error("pending differs from cycle activity");

    // ------------------------------------------------------------
    // flag checks
    // ------------------------------------------------------------

    a_timeout_on_over: assert property (@(posedge clk) disable iff (!reset_n)
        overTime |=> timeout_reg)
        else $error("timeout flag not set");

    a_timeout_rise: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(timeout_reg) |-> $past(overTime))
        else $error("timeout flag set without timeout");

    a_timeout_clear: assert property (@(posedge clk) disable iff (!reset_n)
        (timeout_reg && clearTo && !overTime) |=> !timeout_reg)
        else $error("write of one did not clear timeout");

    // ------------------------------------------------------------
    // local bus checks
    // ------------------------------------------------------------

    a_cs_idle: assert property (@(posedge clk) disable iff (!reset_n)
        (state_reg != guest_mailbox_pkg::ST_ACTIVE) |-> guestCtrl.guestChipSelect == 8'h00)
        else $error("chip select outside cycle");

    a_addr_idle: assert property (@(posedge clk) disable iff (!reset_n)
        (state_reg != guest_mailbox_pkg::ST_ACTIVE) |-> guestCtrl.guestAddress == 3'h0)
        else $error("address lines outside cycle");

    a_dout_en_idle: assert property (@(posedge clk) disable iff (!reset_n)
        idle |-> !guestDataOutEn)
        else $error("data driven while idle");

    a_strobe_excl: assert property (@(posedge clk) disable iff (!reset_n)
        !(guestCtrl.guestReadStrobe && guestCtrl.guestWriteStrobe))
        else $error("read and write strobes together");

    a_drive_write: assert property (@(posedge clk) disable iff (!reset_n)
        guestDataOutEn == guestCtrl.guestWriteStrobe)
        else $error("data enable differs from write strobe");

    a_done_release: assert property (@(posedge clk) disable iff (!reset_n)
        doneCyc |=> guestCtrl == '0)
        else $error("bus not released after cycle");

    a_fields_frozen: assert property (@(posedge clk) disable iff (!reset_n)
        !idle |=> ($stable(guest_reg) && $stable(regSel_reg) && $stable(dir_reg)))
        else $error("fields changed during cycle");

    a_read_capture: assert property (@(posedge clk) disable iff (!reset_n)
        (doneCyc && guestCtrl.guestReadStrobe) |=> byte_reg == $past(guestDataIn))
        else $error("guest byte not captured");

    a_wr_strobe_start: assert property (@(posedge clk) disable iff (!reset_n)
        startCyc |=> guestCtrl.guestWriteStrobe == $past(dir_reg))
        else $error("strobe not taken from direction");

    a_byte_load: assert property (@(posedge clk) disable iff (!reset_n)
        startCyc |=> guestDataOut == $past(wb_dat_i[guest_mailbox_pkg::BYTE_LSB +: 8]))
        else $error("transfer byte not loaded");
endmodule

// ### tb/guest_model.sv
`timescale 1ns/1ns
module guest_model (
    // clock
    input  wire logic                           clk,
    // local bus, guest side
    input  wire guest_mailbox_pkg::guest_ctrl_t guestCtrl,
    output logic [7:0]                          guestDataIn,
    output logic                                guestWaitStrobe_n,
    // stall length in selected clocks, zero answers at once
    input  wire logic [7:0]                     stallCycles
);
    logic [7:0] waitCount = 8'h00;
    logic       selected;
    assign selected = |guestCtrl.guestChipSelect;
    // wait is held low for the first stallCycles selected clocks
    assign guestWaitStrobe_n = !(waitCount < stallCycles);
    initial guestDataIn = 8'h00;
    always @(posedge clk) begin
        waitCount <= selected ? waitCount + 8'h01 : 8'h00;
        // a released data line toggles so a stale byte read does not match the expected byte
        guestDataIn <= selected ? 8'h5a ^ {5'h00, guestCtrl.guestAddress} : ~guestDataIn;
    end
endmodule

// ### tb/guest_bus_mailbox_port_tb.sv
`timescale 1ns/1ns
module guest_bus_mailbox_port_tb;
    logic clk = 1'b0, reset_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, dEn, waitN;
    logic [11:0] adr = 12'h000;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [7:0]  dOut, dIn, stall = 8'h00;
    guest_mailbox_pkg::guest_ctrl_t gc;
    int n_checks = 0, miscompares = 0;
    always #5 clk = ~clk;
    guest_bus_mailbox_port DUT (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .guestCtrl(gc), .guestDataOut(dOut), .guestDataOutEn(dEn),
        .guestDataIn(dIn), .guestWaitStrobe_n(waitN));
    guest_model guest (.clk(clk), .guestCtrl(gc), .guestDataIn(dIn), .guestWaitStrobe_n(waitN),
        .stallCycles(stall));
    // --------
    // shared tasks
    // --------
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [11:0] a, input logic [3:0] s, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, d};
        do @(posedge clk); while (ack !== 1'b1);
        check("ack", 32'h1, 32'(ack));
        q = rdat;
        {cyc, stb, we} <= 3'b000;
    endtask
    task automatic waitIdle;
        for (int n = 0; n < 100 && gc.guestChipSelect !== 8'h00; n++) @(posedge clk);
        check("bus idle", 32'h0, 32'(gc.guestChipSelect));
    endtask
    // --------
    // scenarios
    // --------
    task automatic guestWrites;
        logic [31:0] e;
        for (int g = 0; g < 8; g++) begin
            e = 32'(32'h00800000 | (g << 20) | ((7 - g) << 16) | (g * 17));
            stall <= 8'h08;
            wb(1'b1, 12'h2f0, 4'h4, e);
            wb(1'b1, 12'h200, 4'h1, e);
            #1;
            check("chip select", 32'(8'h01 << g), 32'(gc.guestChipSelect));
            check("write pins", {19'h0, 2'b11, 3'(7 - g), 8'(g * 17)},
                  {19'h0, dEn, gc.guestWriteStrobe, gc.guestAddress, dOut});
            wb(1'b0, 12'h200, 4'hf, 32'h0);
            check("pending set", e | 32'h02000000, q);
            waitIdle;
            wb(1'b0, 12'h2a4, 4'hf, 32'h0);
            check("pending clear", e, q);
        end
    endtask
    task automatic guestRead;
        stall <= 8'h03;
        wb(1'b1, 12'h200, 4'h4, 32'h00350000);
        wb(1'b1, 12'h200, 4'h1, 32'h000000ff);
        #1;
        check("read pins", 32'h2, {30'h0, gc.guestReadStrobe, dEn});
        waitIdle;
        wb(1'b0, 12'h200, 4'hf, 32'h0);
        check("read byte", 32'h0035005f, q);
    endtask
    task automatic timeoutCase;
        int n;
        stall <= 8'hff;
        wb(1'b1, 12'h200, 4'h4, 32'h00f10000);
        wb(1'b1, 12'h200, 4'h1, 32'h000000aa);
        for (n = 0; n < 100 && gc.guestChipSelect !== 8'h00; n++) @(posedge clk);
        check("timeout span", 32'h1, 32'(n >= 61 && n <= 66));
        wb(1'b0, 12'h200, 4'hf, 32'h0);
        check("timeout set", 32'h01f100aa, q);
        wb(1'b1, 12'h200, 4'h8, 32'h0);
        wb(1'b0, 12'h200, 4'hf, 32'h0);
        check("write zero", 32'h01f100aa, q);
        wb(1'b1, 12'h200, 4'h8, 32'h01000000);
        wb(1'b0, 12'h200, 4'hf, 32'h0);
        check("write one", 32'h00f100aa, q);
        stall <= 8'h08;
        wb(1'b1, 12'h200, 4'h1, 32'h0000003c);
        #1;
        check("after timeout", 32'h80, 32'(gc.guestChipSelect));
        waitIdle;
        stall <= 8'h00;
    endtask
    task automatic unmapped;
        wb(1'b1, 12'h040, 4'hf, 32'hffffffff);
        wb(1'b0, 12'h040, 4'hf, 32'h0);
        check("unmapped read", 32'h0, q);
        wb(1'b0, 12'h2fc, 4'hf, 32'h0);
        check("unmapped write", 32'h00f1003c, q);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        tally_and_finish;
    end
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        wb(1'b0, 12'h200, 4'hf, 32'h0);
        check("reset value", 32'h00800000, q);
        guestWrites;
        guestRead;
        timeoutCase;
        unmapped; // unmapped address reads zero and leaves the mailbox unchanged
        tally_and_finish;
    end
endmodule
